//--- test/iru_pic_model.sv
// iru_pic_model: behavioural interrupt controller on the far side of the
// acknowledge pins; raises the maskable request, answers the second strobe.
// assumes: acknowledge strobes always come in pairs after reset.
`timescale 1ns/100ps
`default_nettype none

module iru_pic_model
	import iru_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       raise,
	input  wire logic       drop,
	input  wire logic [7:0] type_in,
	input  wire iru_pins_s  bus_pins,
	output logic            irq_out,
	output logic      [7:0] ad_out
);
	logic       second;
	logic       strobe_q;
	logic [7:0] last;

	// a released bus shows the inverse of its last byte, so stale data fails
	assign ad_out = (second && !bus_pins.irq_ack_strobe_n) ? type_in : ~last;

	// request stays up until the first strobe; pair phase flips per strobe
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_out  <= 1'b0;
			second   <= 1'b0;
			strobe_q <= 1'b1;
			last     <= 8'h00;
		end else begin
			if (raise) begin
				irq_out <= 1'b1;
			end else if (drop || !bus_pins.irq_ack_strobe_n) begin
				irq_out <= 1'b0;
			end
			if (bus_pins.irq_ack_strobe_n && !strobe_q) begin
				second <= !second;
			end
			strobe_q <= bus_pins.irq_ack_strobe_n;
			last     <= ad_out;
		end
	end
endmodule

`default_nettype wire

//--- test/tb_top.sv
// tb_top: self-checking bench for iru_core with the controller model.
// assumes: execution unit acks each ctx step; bus unit cycles by task.
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import iru_pkg::*;
;
	logic        clk_sys = 1'b0, nrst = 1'b0, nmi_in = 1'b0;
	logic        hold_req_in = 1'b0, instr_end = 1'b0, wait_active = 1'b0;
	logic        irq_enable_flag = 1'b0, software_int_op = 1'b0;
	logic        ctx_done = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        raise = 1'b0, drop = 1'b0;
	logic        biu_busy = 1'b0, biu_pending = 1'b0;
	logic [1:0]  biu_tstate = 2'h0;
	iru_kind_e   instr_kind = K_PLAIN;
	logic [7:0]  sw_int_type = 8'h00, pic_type = 8'h00, swt;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
	logic        maskable_irq_in, ret_to_wait, hold_ack, ack_busy;
	logic [7:0]  ad_in;
	iru_pins_s   bus_pins;
	iru_ctx_s    ctx_req;
	int          fail_count = 0, checks_done = 0, cycles = 0, seed = 58;
	int          cnt [8];
	bit          mon_on = 0, saw_busy = 0;
	iru_op_e     last_op = OP_NONE;
	logic [19:0] got_q [$], exp_q [$];

	always #25 clk_sys = ~clk_sys;

	iru_core iru_core_inst (.clk_sys(clk_sys), .nrst(nrst),
		.maskable_irq_in(maskable_irq_in), .nmi_in(nmi_in),
		.hold_req_in(hold_req_in), .ad_in(ad_in), .instr_end(instr_end),
		.instr_kind(instr_kind), .wait_active(wait_active),
		.irq_enable_flag(irq_enable_flag), .software_int_op(software_int_op),
		.sw_int_type(sw_int_type), .ctx_done(ctx_done), .biu_busy(biu_busy),
		.biu_tstate(biu_tstate), .biu_pending(biu_pending),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bus_pins(bus_pins), .ctx_req(ctx_req),
		.ret_to_wait(ret_to_wait), .hold_ack(hold_ack), .ack_busy(ack_busy));

	iru_pic_model iru_pic_model_inst (.clk_sys(clk_sys), .nrst(nrst),
		.raise(raise), .drop(drop), .type_in(pic_type), .bus_pins(bus_pins),
		.irq_out(maskable_irq_in), .ad_out(ad_in));

	// execution unit finishes each context step after one cycle
	always @(posedge clk_sys) begin
		ctx_done <= (ctx_req.op != OP_NONE) && !ctx_done;
	end

	// pin and step recorder; counts live only while a scenario watches
	always @(posedge clk_sys) begin
		if (mon_on) begin
			cnt[0] += !bus_pins.irq_ack_strobe_n;
			cnt[1] += bus_pins.ale;
			cnt[2] += !bus_pins.lock_n;
			cnt[3] += !bus_pins.ad_oe_n;
			cnt[4] += !bus_pins.irq_ack_strobe_n && bus_pins.transceiver_direction !== 1'b0;
			cnt[5] += hold_ack && ack_busy;
			cnt[6] += ret_to_wait;
			cnt[7] += bus_pins.status == STATUS_IRQ_ACK_STROBE_N;
			if (ack_busy) saw_busy = 1;
			if (ctx_req.op != OP_NONE && ctx_req.op !== last_op)
				got_q.push_back({ctx_req.op, (ctx_req.op >= OP_RD_IP_LO) ?
					{6'h00, ctx_req.addr} : (ctx_req.op == OP_CLR_IE_TF ? 16'h0000 : ctx_req.sp_dec)});
			last_op = ctx_req.op;
		end
	end

	// hang guard: far above the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end

	task summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input string what, input logic [19:0] exp, input logic [19:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
			fail_count++;
		end
	endtask

	task reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// the request needs two edges of synchroniser before it counts
	task raise_irq();
		pic_type <= 8'($random(seed));
		@(posedge clk_sys);
		raise <= 1'b1;
		@(posedge clk_sys);
		raise <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask

	task start_mon();
		foreach (cnt[i]) cnt[i] = 0;
		got_q.delete();
		saw_busy = 0;
		mon_on = 1;
	endtask

	task end_instr(input iru_kind_e k, input logic sw, input logic [7:0] t);
		start_mon();
		@(posedge clk_sys);
		instr_end <= 1'b1;
		instr_kind <= k;
		software_int_op <= sw;
		sw_int_type <= t;
		@(posedge clk_sys);
		instr_end <= 1'b0;
		software_int_op <= 1'b0;
	endtask

	// one bus unit cycle T1..T4; with late the instruction ends in T3,
	// after the T2 point at which a request could still claim the bus
	task biu_cycle(input bit late);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_sys);
			biu_busy <= 1'b1;
			biu_tstate <= 2'(s);
			instr_end <= late && s == 2;
		end
		@(posedge clk_sys);
		biu_busy <= 1'b0;
		instr_end <= 1'b0;
	endtask

	// wait for a sequence to start within win cycles, then for its end
	task settle(input int win);
		int n;
		n = 0;
		while (!saw_busy && n < win) begin
			@(posedge clk_sys);
			#1 n++;
		end
		n = 0;
		while (ack_busy !== 1'b0 && n < 200) begin
			@(posedge clk_sys);
			#1 n++;
		end
		repeat (2) @(posedge clk_sys);
		mon_on = 0;
	endtask

	// reference: two acks of 3 strobe clocks, lock over 6, then 8 steps
	task verify(input bit hw, input bit lk, input int t, input bit svc, input bit rt);
		check("strobe_clks", hw ? 6 : 0, cnt[0]);
		check("ale_pulses", hw ? 2 : 0, cnt[1]);
		check("lock_clks", (hw && lk) ? 6 : 0, cnt[2]);
		check("ad_driven", 0, cnt[3]);
		check("dir_not_rx", 0, cnt[4]);
		check("status_clks", hw ? 8 : 0, cnt[7]);
		check("hold_in_seq", 0, cnt[5]);
		check("ret_wait", rt, cnt[6] != 0);
		exp_q.delete();
		for (int k = 0; k < 8 && svc; k++)
			exp_q.push_back({4'(1 + k), (k < 4) ? ((k == 1) ? 16'h0000 : 16'h0002) : 16'(t * 4 + k - 4)});
		check("ctx_count", exp_q.size(), got_q.size());
		foreach (exp_q[i]) if (i < got_q.size()) check("ctx_step", exp_q[i], got_q[i]);
		if (svc) begin
			reg_read(REG_TYPE, rd);
			check("last_type", 20'(t), 20'(rd));
		end
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		#1 check("pins_idle", 20'(PINS_IDLE), 20'(bus_pins));
		reg_read(REG_CTRL, rd);
		check("ctrl_rst", 0, rd);
		reg_read(REG_STAT, rd);
		check("stat_rst", 0, rd);
		reg_read(REG_TYPE, rd);
		check("type_rst", 0, rd);
		reg_write(4'hE, 16'hFFFF);
		reg_read(4'hE, rd);
		check("unmapped", 0, rd);
		// maskable request with a hold arriving mid-sequence
		irq_enable_flag <= 1'b1;
		raise_irq();
		end_instr(K_PLAIN, 1'b0, 8'h00);
		hold_req_in <= 1'b1;
		settle(20);
		verify(1, 0, pic_type, 1, 0);
		repeat (3) @(posedge clk_sys);
		#1 check("hold_grant", 1, hold_ack);
		hold_req_in <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 check("hold_free", 0, hold_ack);
		// enable flag clear: request ignored
		irq_enable_flag <= 1'b0;
		raise_irq();
		end_instr(K_PLAIN, 1'b0, 8'h00);
		settle(12);
		verify(0, 0, 0, 0, 0);
		drop <= 1'b1;
		@(posedge clk_sys);
		drop <= 1'b0;
		// software interrupt runs with enable clear and no acks
		swt = 8'($random(seed));
		end_instr(K_PLAIN, 1'b1, swt);
		settle(12);
		verify(0, 0, swt, 1, 0);
		// non-maskable edge held two clocks, vector 2
		nmi_in <= 1'b1;
		repeat (2) @(posedge clk_sys);
		nmi_in <= 1'b0;
		repeat (3) @(posedge clk_sys);
		end_instr(K_PLAIN, 1'b0, 8'h00);
		settle(12);
		verify(0, 0, 2, 1, 0);
		// segment load defers sampling by one instruction
		irq_enable_flag <= 1'b1;
		raise_irq();
		end_instr(K_SEGLOAD, 1'b0, 8'h00);
		settle(6);
		verify(0, 0, 0, 0, 0);
		end_instr(K_PLAIN, 1'b0, 8'h00);
		settle(20);
		verify(1, 0, pic_type, 1, 0);
		// maximum mode: prefix end skipped, repeat iteration sampled
		reg_write(REG_CTRL, 16'h0001);
		reg_read(REG_CTRL, rd);
		check("ctrl_max", 1, rd);
		raise_irq();
		end_instr(K_PREFIX, 1'b0, 8'h00);
		settle(6);
		verify(0, 1, 0, 0, 0);
		end_instr(K_REPITER, 1'b0, 8'h00);
		settle(20);
		verify(1, 1, pic_type, 1, 0);
		// wait instruction samples every clock and marks the return
		raise_irq();
		start_mon();
		@(posedge clk_sys);
		wait_active <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wait_active <= 1'b0;
		settle(20);
		verify(1, 1, pic_type, 1, 1);
		// bus unit busy: a request seen by its T2 wins over the queue
		biu_pending <= 1'b1;
		raise_irq();
		end_instr(K_PLAIN, 1'b0, 8'h00);
		biu_cycle(1'b0);
		settle(20);
		verify(1, 1, pic_type, 1, 0);
		// request after T2: the queued cycle goes first
		raise_irq();
		start_mon();
		biu_cycle(1'b1);
		repeat (4) @(posedge clk_sys);
		#1 check("late_held", 0, 20'(saw_busy));
		biu_pending <= 1'b0;
		settle(20);
		verify(1, 1, pic_type, 1, 0);
		summarize();
	end
endmodule

`default_nettype wire

//--- verilog/iru_core.sv
// iru_core: maskable, non-maskable and software interrupt recognition,
// the two-cycle acknowledge bus sequence and the context switch steps.
// assumes: execution and bus units run on clk_sys; the execution unit
// stalls instruction ends while ack_busy is high; pins are asynchronous.
// Function
// RQ1: software interrupt type comes from its second byte, ignores enable flag
// RQ2: software interrupts switch at instruction end, no ack cycles, clear IE/TF
// RQ3: maskable request sampled in last clock of instruction, ignored if IE clear
// RQ4: a segment register load does not sample; the next instruction end does
// RQ5: wait instruction samples continuously; return address points back at it
// RQ6: no sampling between a prefix and its instruction
// RQ7: repeated string operations sample after every repetition
// RQ8: request high with enable set at sampling starts acknowledge sequence
// RQ9: requester holds maskable request until acknowledge is issued
// RQ10: request valid two clocks before T4 of running cycle, else one more cycle
// RQ11: pending hold is granted and completed before interrupt service (code: software and non-maskable interrupts start ahead of it)
// RQ12: maskable request is a level synchronised on the rising clock edge
// RQ13: two acknowledge cycles separated by two idle clocks
// RQ14: no address in ack cycles; byte enable, status, ALE, receive direction
// RQ15: first ack cycle floats bus, strobe low T2 to T4, no capture
// RQ16: controller puts type byte on low data byte in second ack cycle
// RQ17: type byte read in second cycle, times four gives vector offset
// RQ18: push flags, clear IE/TF, push code segment and pointer, load vector
// RQ19: minimum mode grants no hold until whole acknowledge sequence ends
// RQ20: maximum mode bus lock from T2 of first ack until T2 of second
// RQ21: non-maskable input asynchronous, rising edge, held two clocks
// RQ22: non-maskable: finish instruction, push flags (SP minus two), vector 2
// RQ23: vector read as pointer low, pointer high, segment low, segment high
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module iru_core
	import iru_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// pins from the outside world
	input  wire logic        maskable_irq_in,
	input  wire logic        nmi_in,
	input  wire logic        hold_req_in,
	input  wire logic [7:0]  ad_in,
	// execution unit
	input  wire logic        instr_end,
	input  wire iru_kind_e   instr_kind,
	input  wire logic        wait_active,
	input  wire logic        irq_enable_flag,
	input  wire logic        software_int_op,
	input  wire logic [7:0]  sw_int_type,
	input  wire logic        ctx_done,
	// bus interface unit
	input  wire logic        biu_busy,
	input  wire logic [1:0]  biu_tstate,
	input  wire logic        biu_pending,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// outputs
	output var iru_pins_s    bus_pins,
	output var iru_ctx_s     ctx_req,
	output logic             ret_to_wait,
	output logic             hold_ack,
	output logic             ack_busy
);

	typedef struct packed {
		logic        irq_s1;
		logic        irq_s2;
		logic        nmi_s1;
		logic        nmi_s2;
		logic        nmi_s3;
		logic        hold_s1;
		logic        hold_s2;
		logic        pend;
		logic        reserved;
		logic        nmi_pend;
		logic        nmi_go;
		logic        sw_pend;
		logic [7:0]  sw_type;
		iru_state_e  st;
		logic [1:0]  tcnt;
		logic [1:0]  gap;
		iru_op_e     step;
		logic [7:0]  vtype;
		logic        is_hw;
		logic        ret_wait;
		logic        max_mode;
		logic [7:0]  last_type;
		logic [15:0] rdata;
		iru_pins_s   pins;
		iru_ctx_s    ctx;
		logic        hold_ack;
		logic        busy;
	} iru_core_s;

	iru_core_s r;
	iru_core_s next_r;

	// next state of the whole unit
	always_comb begin
		logic        sample;
		logic        ack_bus;
		logic [15:0] stat;
		logic [1:0]  byte_idx;
		sample   = 1'b0;
		ack_bus  = 1'b0;
		stat     = 16'h0000;
		byte_idx = 2'h0;
		next_r   = r;

		// two flops on every request pin before any logic reads it; ad_in is read directly
		next_r.irq_s1  = maskable_irq_in;
		next_r.irq_s2  = r.irq_s1;                     // RQ12
		next_r.nmi_s1  = nmi_in;
		next_r.nmi_s2  = r.nmi_s1;
		next_r.nmi_s3  = r.nmi_s2;
		next_r.hold_s1 = hold_req_in;
		next_r.hold_s2 = r.hold_s1;

		// sampling point: end of an instruction that is no prefix and no
		// segment load; each repetition ends with instr_end and samples too
		sample = (instr_end && instr_kind != K_PREFIX    // RQ3 RQ6 RQ7
			&& instr_kind != K_SEGLOAD)                  // RQ4
			|| wait_active;                              // RQ5

		// maskable acceptance latches, so a later drop is harmless; a taken
		// request is not retaken while a wait keeps sampling
		if (sample && r.irq_s2 && irq_enable_flag
			&& !r.pend && !r.busy) begin               // RQ8 RQ9
			next_r.pend     = 1'b1;
			next_r.ret_wait = wait_active;             // RQ5
		end

		// non-maskable: act at the next instruction boundary
		if (r.nmi_pend && (instr_end || wait_active)) begin  // RQ22
			next_r.nmi_pend = 1'b0;
			next_r.nmi_go   = 1'b1;
		end
		// edge set comes after the clear so it is never lost
		if (r.nmi_s2 && !r.nmi_s3) begin
			next_r.nmi_pend = 1'b1;                    // RQ21
		end

		// software interrupt type is the opcode's second byte
		if (instr_end && software_int_op) begin   // RQ1
			next_r.sw_pend = 1'b1;
			next_r.sw_type = sw_int_type;
		end

		// request seen by T2 means two clocks before T4 of this cycle
		if (biu_busy && biu_tstate == T_2 && r.pend) begin
			next_r.reserved = 1'b1;                    // RQ10
		end

		case (r.st)
			ST_IDLE: begin
				if (r.sw_pend) begin
					// no acknowledge cycles for software interrupts
					next_r.sw_pend = 1'b0;             // RQ2
					next_r.vtype   = r.sw_type;
					next_r.is_hw   = 1'b0;
					next_r.st      = ST_CTX;
					next_r.step    = OP_PUSH_FLAGS;
				end else if (r.nmi_go) begin
					next_r.nmi_go = 1'b0;
					next_r.vtype  = NMI_TYPE;          // RQ22
					next_r.is_hw  = 1'b0;
					next_r.st     = ST_CTX;
					next_r.step   = OP_PUSH_FLAGS;
				end else if (r.hold_s2) begin
					next_r.st = ST_HOLD;               // RQ11
				end else if (r.pend && !biu_busy
					&& (r.reserved || !biu_pending)) begin  // RQ10
					next_r.pend     = 1'b0;
					next_r.reserved = 1'b0;
					next_r.is_hw    = 1'b1;
					next_r.st       = ST_ACK1;
					next_r.tcnt     = T_1;
				end
			end
			ST_HOLD: begin
				// the other master finishes before any service
				if (!r.hold_s2) begin
					next_r.st = ST_IDLE;               // RQ11
				end
			end
			ST_ACK1: begin
				// first cycle only announces, nothing is captured
				if (r.tcnt == T_4) begin
					next_r.st  = ST_GAP;               // RQ15
					next_r.gap = 2'(ACK_GAP_CLKS - 2'h1);  // RQ13
				end else begin
					next_r.tcnt = 2'(r.tcnt + 2'h1);
				end
			end
			ST_GAP: begin
				if (r.gap == 2'h0) begin
					next_r.st   = ST_ACK2;             // RQ13
					next_r.tcnt = T_1;
				end else begin
					next_r.gap = 2'(r.gap - 2'h1);
				end
			end
			ST_ACK2: begin
				if (r.tcnt == T_4) begin
					next_r.vtype = ad_in;              // RQ16 RQ17
					next_r.st    = ST_CTX;
					next_r.step  = OP_PUSH_FLAGS;
				end else begin
					next_r.tcnt = 2'(r.tcnt + 2'h1);
				end
			end
			ST_CTX: begin
				// steps advance in fixed order on each completion
				if (ctx_done) begin
					if (r.step == OP_RD_CS_HI) begin   // RQ18 RQ23
						next_r.st        = ST_IDLE;
						next_r.step      = OP_NONE;
						next_r.ret_wait  = 1'b0;
						next_r.last_type = r.vtype;
					end else begin
						next_r.step = iru_op_e'(4'(r.step + 4'h1));
					end
				end
			end
			default: begin
				next_r.st = ST_IDLE;
			end
		endcase

		// bus pins follow the next state so they leave flops
		ack_bus     = (next_r.st == ST_ACK1) || (next_r.st == ST_ACK2);
		next_r.pins = PINS_IDLE;
		if (ack_bus) begin
			// no address driven; strobe and transceiver set to receive
			next_r.pins.ale                   = (next_r.tcnt == T_1);  // RQ14
			next_r.pins.irq_ack_strobe_n      = (next_r.tcnt == T_1);  // RQ15
			next_r.pins.transceiver_direction = 1'b0;  // RQ14
			next_r.pins.transceiver_enable_n  = (next_r.tcnt == T_1);
			next_r.pins.ad_oe_n               = 1'b1;  // RQ15
			next_r.pins.status                = STATUS_IRQ_ACK_STROBE_N;
		end
		// lock spans T2 of the first cycle up to T2 of the second
		if (r.max_mode && ((next_r.st == ST_ACK1 && next_r.tcnt != T_1)
			|| next_r.st == ST_GAP
			|| (next_r.st == ST_ACK2 && next_r.tcnt == T_1))) begin
			next_r.pins.lock_n = 1'b0;                 // RQ20
		end

		// context step request: vector bytes at type times four
		case (next_r.step)
			OP_RD_IP_HI: byte_idx = 2'h1;
			OP_RD_CS_LO: byte_idx = 2'h2;
			OP_RD_CS_HI: byte_idx = 2'h3;
			default:     byte_idx = 2'h0;
		endcase
		next_r.ctx.op   = (next_r.st == ST_CTX) ? next_r.step : OP_NONE;
		next_r.ctx.addr = {next_r.vtype, VEC_PAD} | {8'h00, byte_idx};  // RQ17
		next_r.ctx.sp_dec = (next_r.ctx.op == OP_PUSH_FLAGS
			|| next_r.ctx.op == OP_PUSH_CS
			|| next_r.ctx.op == OP_PUSH_IP) ? SP_PUSH_DEC : 16'h0000;  // RQ22

		// hold is only ever granted from idle, never mid-sequence
		next_r.hold_ack = (next_r.st == ST_HOLD);      // RQ19
		next_r.busy     = (next_r.st != ST_IDLE) && (next_r.st != ST_HOLD);

		// register port
		if (reg_wr && reg_addr == REG_CTRL) begin
			next_r.max_mode = reg_wdata[CTRL_MAX_MODE_BIT];
		end
		stat[STAT_PEND_BIT] = r.pend;
		stat[STAT_NMI_BIT]  = r.nmi_pend | r.nmi_go;
		stat[STAT_BUSY_BIT] = r.busy;
		stat[STAT_HOLD_BIT] = r.hold_ack;
		stat[STAT_WAIT_BIT] = r.ret_wait;
		stat[STAT_SW_BIT]   = r.sw_pend;
		next_r.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: next_r.rdata = {15'h0000, r.max_mode};
				REG_STAT: next_r.rdata = stat;
				REG_TYPE: next_r.rdata = {8'h00, r.last_type};
				default:  next_r.rdata = 16'h0000;
			endcase
		end
	end

	// the one register of the unit
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			r           <= '0;
			r.st        <= ST_IDLE;
			r.step      <= OP_NONE;
			r.max_mode  <= CTRL_MAX_MODE_RST;
			r.last_type <= LAST_TYPE_RST;
			r.pins      <= PINS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign bus_pins    = r.pins;
	assign ctx_req     = r.ctx;
	assign ret_to_wait = r.ret_wait;
	assign hold_ack    = r.hold_ack;
	assign ack_busy    = r.busy;
	assign reg_rdata   = r.rdata;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_sw_no_ack: assert property ( // RQ2
		(r.st == ST_CTX && !r.is_hw) |-> r.pins.irq_ack_strobe_n)
		else $error("ack strobe during software interrupt");

	a_ack_gap_two: assert property ( // RQ13
		(r.st == ST_ACK1 && r.tcnt == T_4)
		|=> (r.st == ST_GAP) [*2] ##1 (r.st == ST_ACK2 && r.tcnt == T_1))
		else $error("gap between ack cycles is not two clocks");

	a_strobe_t2_t4: assert property ( // RQ15
		(r.st == ST_ACK1 && r.tcnt == T_1) |-> r.pins.irq_ack_strobe_n
		##1 (!r.pins.irq_ack_strobe_n) [*3] ##1 r.pins.irq_ack_strobe_n)
		else $error("first ack strobe not low from T2 to T4");

	a_ack_receive: assert property ( // RQ14
		(r.st == ST_ACK1 || r.st == ST_ACK2)
		|-> (r.pins.ad_oe_n && !r.pins.transceiver_direction
		&& r.pins.status == STATUS_IRQ_ACK_STROBE_N))
		else $error("ack cycle drives bus or wrong direction");

	a_lock_span: assert property ( // RQ20
		(r.max_mode && r.st == ST_ACK1 && r.tcnt == T_2)
		|-> (!r.pins.lock_n) [*6] ##1 r.pins.lock_n)
		else $error("bus lock not held T2 to T2");

	a_vec_offset: assert property ( // RQ17
		(r.ctx.op == OP_RD_IP_LO) |-> r.ctx.addr == {r.vtype, 2'b00})
		else $error("vector offset is not type times four");

	// pointer low byte done must be followed by the pointer high byte read
	a_vec_order: assert property ( // RQ23
		(r.ctx.op == OP_RD_IP_LO && ctx_done)
		|=> r.ctx.op == OP_RD_IP_HI)
		else $error("vector bytes out of order");

	a_push_first: assert property ( // RQ18
		(r.ctx.op == OP_PUSH_FLAGS && ctx_done)
		|=> r.ctx.op == OP_CLR_IE_TF)
		else $error("flags push not followed by flag clear");

	a_nmi_caught: assert property ( // RQ21
		(r.nmi_s2 && !r.nmi_s3) |=> (r.nmi_pend || r.nmi_go))
		else $error("non-maskable edge lost");

	a_hold_first: assert property ( // RQ11
		(r.st == ST_HOLD && r.hold_s2) |=> r.st == ST_HOLD && r.hold_ack)
		else $error("service started while hold pending");

	a_no_hold_busy: assert property ( // RQ19
		r.busy |-> !r.hold_ack)
		else $error("hold granted inside acknowledge sequence");

	a_mask_ignore: assert property ( // RQ3
		(!irq_enable_flag && !r.pend && r.st == ST_IDLE) |=> !r.pend)
		else $error("masked request accepted");

endmodule

`default_nettype wire

//--- verilog/iru_pkg.sv
// iru_pkg: constants, types and register map of the interrupt
// recognition and acknowledge unit.
// assumes: one 20 MHz system clock; the execution and bus units share it.
package iru_pkg;

	// processor clock
	localparam int CLK_SYS_HZ = 20_000_000;

	// register port map (word indices)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;
	localparam logic [3:0] REG_TYPE = 4'h2;

	// field positions
	localparam int CTRL_MAX_MODE_BIT = 0;
	localparam int STAT_PEND_BIT     = 0;
	localparam int STAT_NMI_BIT      = 1;
	localparam int STAT_BUSY_BIT     = 2;
	localparam int STAT_HOLD_BIT     = 3;
	localparam int STAT_WAIT_BIT     = 4;
	localparam int STAT_SW_BIT       = 5;

	// reset values
	localparam logic       CTRL_MAX_MODE_RST = 1'b0;
	localparam logic [7:0] LAST_TYPE_RST     = 8'h00;

	// bus T-states
	localparam logic [1:0] T_1 = 2'h0;
	localparam logic [1:0] T_2 = 2'h1;
	localparam logic [1:0] T_3 = 2'h2;
	localparam logic [1:0] T_4 = 2'h3;

	// timing and vector figures
	localparam logic [1:0]  ACK_GAP_CLKS = 2'h2;  // idle clocks between acks
	localparam logic [7:0]  NMI_TYPE     = 8'h02;
	localparam logic [1:0]  VEC_PAD      = 2'h0;  // type times four
	localparam logic [15:0] SP_PUSH_DEC  = 16'h0002;

	// status code shown on the status pins (values are arbitrary)
	localparam logic [2:0] STATUS_IRQ_ACK_STROBE_N    = 3'h0;
	localparam logic [2:0] STATUS_PASSIVE = 3'h7;

	// kind of instruction that ends in the current clock
	typedef enum logic [1:0] {
		K_PLAIN   = 2'h0,
		K_SEGLOAD = 2'h1,
		K_PREFIX  = 2'h2,
		K_REPITER = 2'h3
	} iru_kind_e;

	// context switch micro-operations, in issue order
	typedef enum logic [3:0] {
		OP_NONE       = 4'h0,
		OP_PUSH_FLAGS = 4'h1,
		OP_CLR_IE_TF  = 4'h2,
		OP_PUSH_CS    = 4'h3,
		OP_PUSH_IP    = 4'h4,
		OP_RD_IP_LO   = 4'h5,
		OP_RD_IP_HI   = 4'h6,
		OP_RD_CS_LO   = 4'h7,
		OP_RD_CS_HI   = 4'h8
	} iru_op_e;

	// sequencer states, gray along idle-ack1-gap-ack2-ctx
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ACK1 = 3'b001,
		ST_GAP  = 3'b011,
		ST_ACK2 = 3'b010,
		ST_CTX  = 3'b110,
		ST_HOLD = 3'b100
	} iru_state_e;

	// bus pins owned during acknowledge cycles
	typedef struct packed {
		logic       ale;
		logic       irq_ack_strobe_n;
		logic       lock_n;
		logic       transceiver_direction;
		logic       transceiver_enable_n;
		logic       high_byte_enable_n;
		logic       ad_oe_n;
		logic [2:0] status;
	} iru_pins_s;

	localparam iru_pins_s PINS_IDLE = '{
		ale: 1'b0, irq_ack_strobe_n: 1'b1, lock_n: 1'b1,
		transceiver_direction: 1'b1, transceiver_enable_n: 1'b1,
		high_byte_enable_n: 1'b1, ad_oe_n: 1'b1, status: STATUS_PASSIVE};

	// request to the execution unit for one context step
	typedef struct packed {
		iru_op_e     op;
		logic [9:0]  addr;
		logic [15:0] sp_dec;
	} iru_ctx_s;

endpackage
